// File: rtl/lpc_dev.sv
/*
 Device end: low-power state machine and thermal throttle.
 Assumes the chipset end drives the link on the same clock; sensor pins
 are asynchronous and are synchronised here.
*/
`timescale 1ns/10ps
`include "lpc_defines.svh"
module lpc_dev #(
   parameter int GRANT_DELAY = `LPC_GRANT_DELAY,
   parameter int HYST_CYC = `LPC_HYST_CYC,
   parameter int STEP_CYC = `LPC_STEP_CYC
) (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   lpc_link_if.dev link,
   input wire logic halt_instr_in,
   input wire logic auto_mode_en_in,
   input wire logic therm_irq_en_in,
   input wire logic temp_hot_in,
   input wire logic temp_crit_in,
   output logic core_clk_en_out,
   output logic core_init_out,
   output logic [3:0] event_service_out,
   output logic thermal_event_out,
   output lpc_pkg::lpc_state_t state_out
);
   import lpc_pkg::*;
   localparam int GW = $clog2(GRANT_DELAY + 1);
   localparam int HW = $clog2(HYST_CYC + 1);

   // ------------------------------------------------------------
   // Sensor synchronisers
   // ------------------------------------------------------------
   logic hot_s1_q;
   logic hot_s2_q;
   logic crit_s1_q;
   logic crit_s2_q;

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         hot_s1_q <= 1'b0;
         hot_s2_q <= 1'b0;
         crit_s1_q <= 1'b0;
         crit_s2_q <= 1'b0;
      end else begin
         hot_s1_q <= temp_hot_in;
         hot_s2_q <= hot_s1_q;
         crit_s1_q <= temp_crit_in;
         crit_s2_q <= crit_s1_q;
      end
   end

   // ------------------------------------------------------------
   // State machine
   // ------------------------------------------------------------
   lpc_state_t state_q;
   lpc_state_t state_d;
   lpc_state_t origin_q;
   logic resume_halt_q;
   logic [GW-1:0] gcnt_q;
   logic [3:0] pend_q;
   logic [3:0] svc_q;
   logic done_q;
   logic ack_q;
   logic brk_q;
   logic init_q;

   wire rst_pin = link.cpu_reset;
   wire stop_req = link.stop_clock_request;
   wire sleeping = state_q == LPC_SLEEP;
   wire [3:0] ev_in = {
      (|link.local_interrupt_lines) | link.bus_irq_msg,
      link.soft_init,
      link.bus_init_error,
      link.system_mgmt_interrupt
   };
   // Events are latched in every state but sleep; only normal drains them
   wire [3:0] svc = (state_q == LPC_NORMAL) ? pend_q : 4'h0; // RL6
   wire [3:0] pend_d = sleeping ? pend_q : ((pend_q & ~svc) | ev_in); // RL7
   // Done is held off one cycle so a request still high is not re-taken
   wire snoop_ev = link.snoop_req & ~done_q & ~sleeping; // RL15
   wire wake = snoop_ev | link.bus_irq_msg;
   wire grant_end = gcnt_q == GW'(GRANT_DELAY - 1);
   wire done_d = link.snoop_req & ~done_q &
      ((state_q == LPC_NORMAL) | (state_q == LPC_SNOOP)); // RL11
   wire ack_d = (state_d == LPC_GRANT_WAIT) &
      (state_q != LPC_GRANT_WAIT); // RL4
   wire in_grant = (state_q == LPC_STOP_GRANT) |
      ((state_q == LPC_SNOOP) & (origin_q == LPC_STOP_GRANT));
   // Pending includes interrupts masked by the interrupt enable flag
   wire brk_d = in_grant & (|pend_q); // RL14

   always_comb begin
      state_d = state_q;
      case (state_q)
         LPC_NORMAL: begin
            if (stop_req) begin
               state_d = LPC_GRANT_WAIT;
            end else if (halt_instr_in) begin
               state_d = LPC_HALT; // RL1
            end
         end
         LPC_HALT: begin
            if (stop_req) begin
               state_d = LPC_GRANT_WAIT;
            end else if ((|pend_q) | (|ev_in)) begin
               state_d = LPC_NORMAL; // RL1
            end else if (wake) begin
               state_d = LPC_SNOOP; // RL3
            end
         end
         LPC_GRANT_WAIT: begin
            if (grant_end) begin
               state_d = LPC_STOP_GRANT; // RL4
            end
         end
         LPC_STOP_GRANT: begin
            if (!stop_req) begin
               state_d = resume_halt_q ? LPC_HALT : LPC_NORMAL; // RL9 RL2
            end else if (link.sleep_request) begin
               state_d = LPC_SLEEP; // RL12
            end else if (wake) begin
               state_d = LPC_SNOOP; // RL11
            end
         end
         LPC_SNOOP: begin
            state_d = origin_q; // RL11
         end
         LPC_SLEEP: begin
            if (!link.sleep_request) begin
               state_d = LPC_STOP_GRANT;
            end
         end
         default: begin
            state_d = LPC_NORMAL;
         end
      endcase
      if (rst_pin) begin
         // Sleep resets straight to normal; grant holds until stop drops
         state_d = (state_q == LPC_STOP_GRANT && stop_req) ? LPC_STOP_GRANT
            : LPC_NORMAL; // RL8 RL17
      end
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_q <= LPC_NORMAL;
         origin_q <= LPC_HALT;
         resume_halt_q <= 1'b0;
         gcnt_q <= '0;
         pend_q <= 4'h0;
         svc_q <= 4'h0;
         done_q <= 1'b0;
         ack_q <= 1'b0;
         brk_q <= 1'b0;
         init_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (state_d == LPC_SNOOP && state_q != LPC_SNOOP) begin
            origin_q <= state_q;
         end
         if (ack_d) begin
            resume_halt_q <= state_q == LPC_HALT; // RL2
         end else if (state_q == LPC_NORMAL) begin
            resume_halt_q <= 1'b0;
         end
         gcnt_q <= (state_q == LPC_GRANT_WAIT) ? gcnt_q + GW'(1) : '0;
         pend_q <= rst_pin ? 4'h0 : pend_d;
         svc_q <= rst_pin ? 4'h0 : svc; // RL6
         done_q <= done_d;
         ack_q <= ack_d;
         brk_q <= brk_d;
         init_q <= rst_pin; // RL1
      end
   end

   // ------------------------------------------------------------
   // Thermal throttle
   // ------------------------------------------------------------
   logic [7:0] tcr_q;
   logic auto_act_q;
   logic [HW-1:0] hcnt_q;
   logic hot_q;
   logic trip_q;
   logic tev_q;
   logic clk_en_q;
   logic thr_on;

   wire hot = hot_s2_q;
   wire [HW-1:0] hcnt_d = hot ? HW'(HYST_CYC)
      : ((hcnt_q != '0) ? hcnt_q - HW'(1) : '0);
   // Throttle holds until the hysteresis count runs out after cooling
   wire auto_act_d = auto_mode_en_in &
      (hot | (auto_act_q & (hcnt_q != '0))); // RL19
   wire thr_en = auto_act_q | tcr_q[`LPC_TCR_ODM_BIT]; // RL20
   wire [2:0] thr_duty = auto_act_q ? `LPC_AUTO_DUTY
      : tcr_q[`LPC_TCR_DUTY_MSB:`LPC_TCR_DUTY_LSB]; // RL21
   wire trip_d = crit_s2_q | (trip_q & ~rst_pin); // RL23
   wire clk_en_d = ~trip_q & ~rst_pin &
      (((state_q == LPC_NORMAL) & thr_on) |
       (state_q == LPC_GRANT_WAIT)); // RL15

   lpc_duty_gen #(
      .STEP_CYC(STEP_CYC)
   ) u_lpc_duty_gen (
      .ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in),
      .enable_in(thr_en),
      .duty_in(thr_duty),
      .clk_on_out(thr_on)
   );

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         tcr_q <= `LPC_TCR_RST;
         auto_act_q <= 1'b0;
         hcnt_q <= '0;
         hot_q <= 1'b0;
         trip_q <= 1'b0;
         tev_q <= 1'b0;
         clk_en_q <= 1'b0;
      end else begin
         if (rst_pin) begin
            tcr_q <= `LPC_TCR_RST;
         end else if (link.tcr_wr) begin
            tcr_q <= link.tcr_wdata & `LPC_TCR_MASK; // RL20
         end
         auto_act_q <= auto_act_d;
         hcnt_q <= hcnt_d;
         hot_q <= hot; // RL22
         trip_q <= trip_d;
         tev_q <= therm_irq_en_in & (hot != hot_q); // RL22
         clk_en_q <= clk_en_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign link.snoop_done = done_q;
   assign link.stop_grant_ack = ack_q;
   assign link.pending_break_out = brk_q;
   assign link.overtemp_indicator = hot_q;
   assign link.thermal_trip_shutdown = trip_q;
   assign link.tcr_rdata = tcr_q;
   assign link.dev_state = state_q;
   assign core_clk_en_out = clk_en_q;
   assign core_init_out = init_q;
   assign event_service_out = svc_q;
   assign thermal_event_out = tev_q;
   assign state_out = state_q;
endmodule

// File: rtl/lpc_defines.svh
/*
 Constants of the low-power clock control pair: link timing, thermal
 control field layout, throttle figures and the controller's own register
 map. Assumes one 200 MHz clock shared by both ends.
*/
// Functional notes
// RL1 - Halt instruction enters halt; events or reset wake
// RL2 - Stop-clock from halt resumes into halt
// RL3 - Halt still serves snoops and interrupts
// RL4 - Grant acknowledge, then grant 20 clocks later
// RL5 - Chipset keeps bus inputs inactive during grant
// RL6 - Grant latches events; one service each later
// RL7 - Bus init error stays pending through grant
// RL8 - Reset in grant initializes, stays in grant
// RL9 - Stop-clock release returns grant to normal
// RL10 - Release stop-clock one clock after sleep
// RL11 - Snoop or interrupt visits snoop state, returns
// RL12 - Sleep entered only from grant on request
// RL13 - Chipset requests sleep only during grant
// RL14 - Pending-break output flags latched interrupts in grant
// RL15 - Sleep stops clocks, no snoops, no latching
// RL16 - Chipset keeps bus quiet while device sleeps
// RL17 - Reset in sleep resets directly; drop requests
// RL18 - Sleep held one clock, dropped before events
// RL19 - Hot throttles at factory duty; hysteresis exit
// RL20 - Bit 4 forces throttle; bits 3:1 duty
// RL21 - Automatic duty overrides programmed duty when hot
// RL22 - Overtemp output follows hot sensor; edge event optional
// RL23 - Catastrophic trip output sticky until reset
// RL24 - Duty code zero keeps clocks running
`ifndef LPC_DEFINES_SVH
`define LPC_DEFINES_SVH

`define LPC_CLK_PERIOD_NS 5
`define LPC_GRANT_DELAY 20
`define LPC_HYST_NS 1000
`define LPC_HYST_CYC \
   ((`LPC_HYST_NS + `LPC_CLK_PERIOD_NS - 1) / `LPC_CLK_PERIOD_NS)
`define LPC_STEP_CYC 16
`define LPC_AUTO_DUTY 3'h4

`define LPC_TCR_ODM_BIT 4
`define LPC_TCR_DUTY_MSB 3
`define LPC_TCR_DUTY_LSB 1
`define LPC_TCR_RST 8'h00
`define LPC_TCR_MASK 8'h1E

`define LPC_EV_MGMT 0
`define LPC_EV_BUSERR 1
`define LPC_EV_INIT 2
`define LPC_EV_LOCAL 3

`define LPC_CTRL_OFS 12'h000
`define LPC_EVT_OFS 12'h004
`define LPC_TCR_OFS 12'h008
`define LPC_STAT_OFS 12'h00C
`define LPC_CTRL_STOP 0
`define LPC_CTRL_SLEEP 1
`define LPC_CTRL_RESET 2
`define LPC_EVT_SNOOP 5
`define LPC_STAT_ACK 7
`define LPC_CTRL_RST 3'h0
`define LPC_EVT_PULSE_MASK 7'h5F

`endif

// File: rtl/lpc_pkg.sv
/*
 Types shared by both ends of the low-power clock control link.
 Assumes nothing beyond the constants header.
*/
package lpc_pkg;
   typedef enum logic [2:0] {
      LPC_NORMAL,
      LPC_HALT,
      LPC_GRANT_WAIT,
      LPC_STOP_GRANT,
      LPC_SNOOP,
      LPC_SLEEP
   } lpc_state_t;
endpackage

// File: rtl/lpc_link_if.sv
/*
 Link between the clocked device and the chipset logic.
 Assumes both ends run on the same clock; every signal is a plain level
 or a one-cycle pulse, active high.
*/
`timescale 1ns/10ps
interface lpc_link_if;
   import lpc_pkg::*;
   logic stop_clock_request;
   logic sleep_request;
   logic cpu_reset;
   logic system_mgmt_interrupt;
   logic bus_init_error;
   logic soft_init;
   logic [1:0] local_interrupt_lines;
   logic snoop_req;
   logic bus_irq_msg;
   logic tcr_wr;
   logic [7:0] tcr_wdata;
   logic snoop_done;
   logic stop_grant_ack;
   logic pending_break_out;
   logic overtemp_indicator;
   logic thermal_trip_shutdown;
   logic [7:0] tcr_rdata;
   lpc_state_t dev_state;
   modport dev(
      input stop_clock_request, sleep_request, cpu_reset,
      input system_mgmt_interrupt, bus_init_error, soft_init,
      input local_interrupt_lines, snoop_req, bus_irq_msg,
      input tcr_wr, tcr_wdata,
      output snoop_done, stop_grant_ack, pending_break_out,
      output overtemp_indicator, thermal_trip_shutdown, tcr_rdata,
      output dev_state
   );
   modport host(
      output stop_clock_request, sleep_request, cpu_reset,
      output system_mgmt_interrupt, bus_init_error, soft_init,
      output local_interrupt_lines, snoop_req, bus_irq_msg,
      output tcr_wr, tcr_wdata,
      input snoop_done, stop_grant_ack, pending_break_out,
      input overtemp_indicator, thermal_trip_shutdown, tcr_rdata,
      input dev_state
   );
endinterface

// File: rtl/lpc_duty_gen.sv
/*
 Duty-cycle gate for the core clocks: eight steps per period, the first
 duty steps on. Assumes duty and enable come from the same clock.
*/
`timescale 1ns/10ps
`include "lpc_defines.svh"
module lpc_duty_gen #(
   parameter int STEP_CYC = `LPC_STEP_CYC
) (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic enable_in,
   input wire logic [2:0] duty_in,
   output logic clk_on_out
);
   localparam int SW = $clog2(STEP_CYC + 1);
   logic [SW-1:0] step_q;
   logic [2:0] phase_q;
   logic on_q;
   wire step_end = step_q == SW'(STEP_CYC - 1);
   wire on_d = ~enable_in | (duty_in == 3'h0) | (phase_q < duty_in); // RL24

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         step_q <= '0;
         phase_q <= 3'h0;
         on_q <= 1'b1;
      end else begin
         step_q <= step_end ? '0 : step_q + SW'(1);
         phase_q <= step_end ? phase_q + 3'h1 : phase_q;
         on_q <= on_d; // RL20
      end
   end
   assign clk_on_out = on_q;
endmodule

// File: rtl/lpc_host.sv
/*
 Chipset end: APB registers that drive the link toward the device and
 report its state. Assumes an APB master on the same clock.
*/
`timescale 1ns/10ps
`include "lpc_defines.svh"
module lpc_host (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   lpc_link_if.host link
);
   import lpc_pkg::*;

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   logic [2:0] ctrl_q;
   logic [6:0] evp_q;
   logic ack_seen_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [2:0] st_code;

   assign st_code = link.dev_state;
   wire setup = psel_in & ~penable_in;
   wire wr = psel_in & penable_in & pready_q & pwrite_in;
   wire sel_ctrl = paddr_in == `LPC_CTRL_OFS;
   wire sel_evt = paddr_in == `LPC_EVT_OFS;
   wire sel_tcr = paddr_in == `LPC_TCR_OFS;
   wire sel_stat = paddr_in == `LPC_STAT_OFS;
   wire mapped = sel_ctrl | sel_evt | sel_tcr | sel_stat;
   wire [31:0] rd_mux = sel_ctrl ? {29'h0, ctrl_q}
      : sel_evt ? {25'h0, evp_q}
      : sel_tcr ? {24'h0, link.tcr_rdata}
      : sel_stat ? {24'h0, ack_seen_q, link.thermal_trip_shutdown,
         link.overtemp_indicator, link.pending_break_out, 1'b0, st_code}
      : 32'h0;

   // ------------------------------------------------------------
   // Link sequencing
   // ------------------------------------------------------------
   logic stop_q;
   logic sleep_q;
   logic rst_q;
   logic snoop_q;
   logic [6:0] iss_q;
   logic tcr_wr_q;
   logic [7:0] tcr_wdata_q;

   wire dev_sleep = link.dev_state == LPC_SLEEP;
   wire dev_grant = link.dev_state == LPC_STOP_GRANT;
   // Nothing else moves on the bus while sleep is requested or held
   wire allowed = ~sleep_q & ~dev_sleep & ~rst_q; // RL16 RL18
   wire [6:0] iss = allowed ? (evp_q & {1'b1, ~snoop_q, 5'h1F}) : 7'h0;
   wire [6:0] evp_set = (wr & sel_evt) ? pwdata_in[6:0] : 7'h0;
   wire kill = ctrl_q[`LPC_CTRL_RESET] & (dev_sleep | sleep_q); // RL17
   wire sleep_d = ctrl_q[`LPC_CTRL_SLEEP] & ~ctrl_q[`LPC_CTRL_RESET] &
      ~snoop_q & (dev_grant | dev_sleep); // RL13 RL16
   // Holding stop with the previous sleep level delays its release
   wire stop_d = (ctrl_q[`LPC_CTRL_STOP] | sleep_q) & ~kill; // RL10
   wire ack_clr = wr & sel_stat & pwdata_in[`LPC_STAT_ACK];

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ctrl_q <= `LPC_CTRL_RST;
         evp_q <= 7'h0;
         ack_seen_q <= 1'b0;
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         stop_q <= 1'b0;
         sleep_q <= 1'b0;
         rst_q <= 1'b0;
         snoop_q <= 1'b0;
         iss_q <= 7'h0;
         tcr_wr_q <= 1'b0;
         tcr_wdata_q <= 8'h00;
      end else begin
         pready_q <= setup;
         prdata_q <= (setup & ~pwrite_in) ? rd_mux : 32'h0;
         pslverr_q <= setup & ~mapped;
         if (wr & sel_ctrl) begin
            ctrl_q <= pwdata_in[2:0];
         end
         evp_q <= (evp_q & ~iss) | evp_set;
         ack_seen_q <= link.stop_grant_ack | (ack_seen_q & ~ack_clr);
         stop_q <= stop_d;
         sleep_q <= sleep_d; // RL18
         rst_q <= ctrl_q[`LPC_CTRL_RESET];
         // Pulse events leave as single cycles so idle pins stay inactive
         iss_q <= iss & `LPC_EVT_PULSE_MASK; // RL5
         snoop_q <= iss[`LPC_EVT_SNOOP] | (snoop_q & ~link.snoop_done);
         tcr_wr_q <= wr & sel_tcr & allowed;
         if (wr & sel_tcr) begin
            tcr_wdata_q <= pwdata_in[7:0];
         end
      end
   end

   assign prdata_out = prdata_q;
   assign pready_out = pready_q;
   assign pslverr_out = pslverr_q;
   assign link.stop_clock_request = stop_q;
   assign link.sleep_request = sleep_q;
   assign link.cpu_reset = rst_q;
   assign link.system_mgmt_interrupt = iss_q[0];
   assign link.bus_init_error = iss_q[1];
   assign link.soft_init = iss_q[2];
   assign link.local_interrupt_lines = iss_q[4:3];
   assign link.bus_irq_msg = iss_q[6];
   assign link.snoop_req = snoop_q;
   assign link.tcr_wr = tcr_wr_q;
   assign link.tcr_wdata = tcr_wdata_q;
endmodule

// File: sim/lpc_link_monitor.sv
/*
 Checker for the device side of the link between the two ends.
 Assumes it is instantiated in the bench beside the link interface.
*/
`timescale 1ns/10ps
`include "lpc_defines.svh"
module lpc_link_monitor (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic stop_clock_request,
   input wire logic sleep_request,
   input wire logic cpu_reset,
   input wire logic system_mgmt_interrupt,
   input wire logic snoop_req,
   input wire logic snoop_done,
   input wire logic stop_grant_ack,
   input wire logic pending_break_out,
   input wire logic thermal_trip_shutdown,
   input wire logic [7:0] tcr_rdata,
   input wire lpc_pkg::lpc_state_t dev_state
);
   import lpc_pkg::*;
   // ---------------
   // Link properties
   // ---------------
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   ack_state_a: assert property (stop_grant_ack |->
      dev_state == LPC_GRANT_WAIT)
      else $error("grant ack outside grant wait");
   grant_delay_a: assert property (stop_grant_ack && !cpu_reset |->
      ##19 dev_state == LPC_GRANT_WAIT ##1 dev_state == LPC_STOP_GRANT)
      else $error("grant not entered 20 clocks after ack");
   grant_exit_a: assert property (dev_state == LPC_STOP_GRANT &&
      !stop_clock_request && !sleep_request && !snoop_req
      |=> dev_state inside {LPC_NORMAL, LPC_HALT})
      else $error("grant kept after stop release");
   sleep_entry_a: assert property (dev_state == LPC_STOP_GRANT &&
      sleep_request && !snoop_req |=> dev_state == LPC_SLEEP)
      else $error("sleep not entered from grant");
   sleep_from_a: assert property ($changed(dev_state) &&
      dev_state == LPC_SLEEP |-> $past(dev_state) == LPC_STOP_GRANT)
      else $error("sleep entered from wrong state");
   sleep_quiet_a: assert property (dev_state == LPC_SLEEP |->
      !snoop_done && !stop_grant_ack)
      else $error("activity while asleep");
   grant_snoop_a: assert property (dev_state == LPC_STOP_GRANT &&
      $rose(snoop_req) && !sleep_request |=> dev_state == LPC_SNOOP
      ##1 snoop_done ##[0:1] dev_state == LPC_STOP_GRANT)
      else $error("snoop from grant mishandled");
   halt_snoop_a: assert property (dev_state == LPC_HALT &&
      $rose(snoop_req) |=> dev_state == LPC_SNOOP ##1 snoop_done)
      else $error("snoop from halt mishandled");
   brk_where_a: assert property (pending_break_out |->
      dev_state inside {LPC_STOP_GRANT, LPC_SNOOP} ||
      $past(dev_state) inside {LPC_STOP_GRANT, LPC_SNOOP})
      else $error("pending break outside grant");
   brk_raise_a: assert property (dev_state == LPC_STOP_GRANT &&
      system_mgmt_interrupt |-> ##[1:2] pending_break_out)
      else $error("latched event gave no pending break");
   trip_hold_a: assert property (thermal_trip_shutdown && !cpu_reset
      |=> thermal_trip_shutdown)
      else $error("trip output dropped without reset");
   tcr_rsvd_a: assert property ((tcr_rdata & ~`LPC_TCR_MASK) == 8'h00)
      else $error("reserved control bits read nonzero");
endmodule

// File: sim/lpc_tb.sv
/*
 Self-checking bench: device and chipset ends joined by the link, driven
 through the chipset's APB registers. Assumes design and monitor compiled.
*/
`timescale 1ns/10ps
`include "lpc_defines.svh"
module lpc_tb;
   import lpc_pkg::*;
   logic ref_clk_in = 1'h0;
   logic sys_rst_in = 1'h1;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, rerr, clk_en, init, th_ev;
   logic halt = 1'h0, auto_en = 1'h0, irq_en = 1'h0, hot = 1'h0, crit = 1'h0;
   logic [3:0] svc;
   lpc_state_t dst;
   int svc_n[4] = '{default: 0};
   int th_n = 0;
   int dn_n = 0;
   int n_fail = 0;
   int check_count = 0;
   lpc_link_if lk();
   always #2.5 ref_clk_in = ~ref_clk_in;
   // Short hysteresis and step keep the throttle windows brief
   lpc_dev #(.HYST_CYC(4), .STEP_CYC(2)) u_lpc_dev (.ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in), .link(lk.dev), .halt_instr_in(halt),
      .auto_mode_en_in(auto_en), .therm_irq_en_in(irq_en),
      .temp_hot_in(hot), .temp_crit_in(crit), .core_clk_en_out(clk_en),
      .core_init_out(init), .event_service_out(svc),
      .thermal_event_out(th_ev), .state_out(dst));
   lpc_host u_lpc_host (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .link(lk.host));
   lpc_link_monitor u_lpc_link_monitor (.ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in), .stop_clock_request(lk.stop_clock_request),
      .sleep_request(lk.sleep_request), .cpu_reset(lk.cpu_reset),
      .system_mgmt_interrupt(lk.system_mgmt_interrupt),
      .snoop_req(lk.snoop_req), .snoop_done(lk.snoop_done),
      .stop_grant_ack(lk.stop_grant_ack),
      .pending_break_out(lk.pending_break_out),
      .thermal_trip_shutdown(lk.thermal_trip_shutdown),
      .tcr_rdata(lk.tcr_rdata), .dev_state(lk.dev_state));
   always @(posedge ref_clk_in) begin
      for (int i = 0; i < 4; i++) begin
         svc_n[i] += int'(svc[i] === 1'h1);
      end
      th_n += int'(th_ev === 1'h1);
      dn_n += int'(lk.snoop_done === 1'h1);
   end
   // -----------
   // Shared tasks
   // -----------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One idle cycle after each transfer so psel is never set twice a step
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk_in);
      penable <= 1'h1;
      do begin
         @(posedge ref_clk_in);
      end while (pready !== 1'h1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge ref_clk_in);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask
   task automatic rd(input logic [11:0] a);
      apb(1'h0, a, 32'h0);
   endtask
   task automatic wait_state(input logic [2:0] s);
      int n;
      n = 0;
      do begin
         rd(`LPC_STAT_OFS);
         n++;
      end while (rdat[2:0] !== s && n < 40);
      chk(rdat[2:0], s);
      chk(dst, s);
   endtask
   task automatic count_on(input int exp);
      int n;
      n = 0;
      repeat (32) @(posedge ref_clk_in);
      repeat (64) begin
         @(posedge ref_clk_in);
         n += int'(clk_en === 1'h1);
      end
      chk(n, exp);
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d fails=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk_in);
      n_fail++;
      tally_and_finish;
   end
   // -----
   // Tests
   // -----
   initial begin
      repeat (8) @(posedge ref_clk_in);
      sys_rst_in <= 1'h0;
      rd(`LPC_STAT_OFS);
      chk(rdat, 32'h0);
      rd(`LPC_TCR_OFS);
      chk(rdat, 32'h0);
      rd(12'h010);
      chk({rerr, rdat[30:0]}, 32'h80000000);
      $display("reset and map done");
      wr(`LPC_CTRL_OFS, 32'h1);
      wait_state(3'h3);
      chk(rdat[7], 1'h1);
      wr(`LPC_EVT_OFS, 32'h3);
      wr(`LPC_EVT_OFS, 32'h1);
      rd(`LPC_STAT_OFS);
      chk(rdat[4], 1'h1);
      chk(svc_n[0] + svc_n[1], 0);
      wr(`LPC_EVT_OFS, 32'h20);
      wait_state(3'h3);
      wr(`LPC_CTRL_OFS, 32'h3);
      wait_state(3'h5);
      chk(clk_en, 1'h0);
      chk(dn_n, 1);
      wr(`LPC_CTRL_OFS, 32'h1);
      wait_state(3'h3);
      wr(`LPC_CTRL_OFS, 32'h0);
      wait_state(3'h0);
      chk(svc_n[0], 1);
      chk(svc_n[1], 1);
      $display("grant and sleep done");
      halt <= 1'h1;
      @(posedge ref_clk_in);
      halt <= 1'h0;
      wait_state(3'h1);
      chk(clk_en, 1'h0);
      wr(`LPC_EVT_OFS, 32'h20);
      wait_state(3'h1);
      wr(`LPC_CTRL_OFS, 32'h1);
      wait_state(3'h3);
      wr(`LPC_CTRL_OFS, 32'h0);
      wait_state(3'h1);
      chk(dn_n, 2);
      wr(`LPC_EVT_OFS, 32'h8);
      wait_state(3'h0);
      chk(svc_n[3], 1);
      $display("halt done");
      wr(`LPC_CTRL_OFS, 32'h1);
      wait_state(3'h3);
      wr(`LPC_CTRL_OFS, 32'h5);
      rd(`LPC_STAT_OFS);
      chk(rdat[2:0], 3'h3);
      chk(init, 1'h1);
      wr(`LPC_CTRL_OFS, 32'h1);
      wr(`LPC_CTRL_OFS, 32'h3);
      wait_state(3'h5);
      wr(`LPC_CTRL_OFS, 32'h7);
      wait_state(3'h0);
      wr(`LPC_CTRL_OFS, 32'h0);
      $display("reset in low power done");
      irq_en <= 1'h1;
      for (int d = 0; d < 8; d++) begin
         wr(`LPC_TCR_OFS, 32'h10 | (d << 1));
         rd(`LPC_TCR_OFS);
         chk(rdat, 32'h10 | (d << 1));
         count_on(d == 0 ? 64 : d * 8);
      end
      auto_en <= 1'h1;
      hot <= 1'h1;
      wr(`LPC_TCR_OFS, 32'h1E);
      count_on(`LPC_AUTO_DUTY * 8);
      rd(`LPC_STAT_OFS);
      chk(rdat[5], 1'h1);
      wr(`LPC_TCR_OFS, 32'h0);
      count_on(`LPC_AUTO_DUTY * 8);
      hot <= 1'h0;
      count_on(64);
      chk(th_n, 2);
      $display("throttle done");
      crit <= 1'h1;
      repeat (8) @(posedge ref_clk_in);
      crit <= 1'h0;
      repeat (8) @(posedge ref_clk_in);
      rd(`LPC_STAT_OFS);
      chk({rdat[6], clk_en}, 2'h2);
      wr(`LPC_CTRL_OFS, 32'h4);
      wr(`LPC_CTRL_OFS, 32'h0);
      rd(`LPC_STAT_OFS);
      chk(rdat[6], 1'h0);
      $display("trip done");
      tally_and_finish;
   end
endmodule
